// ==== logic/lt_pkg.sv ====
// shared constants and types of the single-wire link transceiver control
// Functional notes
// - host txd low drives bus dominant in normal mode
// - txd high or open releases bus
// - txd low over 6 ms forces recessive
// - re-arm after txd high over 10 us
// - build option removes dominant time-out
// - fail-safe drives txd low after local wake
// - power-on enters fail-safe, regulator on
// - battery undervoltage blocks all transmission
// - reset combines undervoltage and watchdog, 4 ms
// - falling kick edge services watchdog
// - mode-select high disables watchdog
// - enable high enters normal mode
// - wake from bus, switch, ignition edge
// - receive output follows bus level in normal mode
// - enable falling picks silent or sleep
// - reset in normal forces fail-safe
package lt_pkg;

  localparam int CLK_MHZ          = 125;
  localparam int DOM_TIME_US      = 6000;
  localparam int REARM_TIME_NS    = 10000;
  localparam int RST_TIME_US      = 4000;
  localparam int WD_TIME_US       = 20000;
  localparam logic [23:0] DOM_CYC = 24'(DOM_TIME_US * CLK_MHZ);
  localparam logic [10:0] REARM_CYC = 11'((REARM_TIME_NS * CLK_MHZ + 999) / 1000);
  localparam logic [23:0] RST_CYC = 24'(RST_TIME_US * CLK_MHZ);
  localparam logic [23:0] WD_CYC  = 24'(WD_TIME_US * CLK_MHZ);

  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STATUS   = 8'h04;
  localparam logic [7:0] A_IRQ_STAT = 8'h08;
  localparam logic [7:0] A_IRQ_EN   = 8'h0C;
  localparam logic [7:0] A_IRQ_CLR  = 8'h10;

  localparam int CTRL_TO_EN  = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;

  localparam int IRQ_W       = 5;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_WAKE    = 1;
  localparam int IRQ_WDOG    = 2;
  localparam int IRQ_REG_UV  = 3;
  localparam int IRQ_BATT_UV = 4;

  typedef enum logic [1:0] {
    FAILSAFE,
    NORMAL,
    SILENT,
    SLEEP
  } lt_mode_e;

  typedef struct packed {
    logic txd;
    logic lin;
    logic wake_sw;
    logic ign;
    logic en;
    logic wd_off;
    logic kick_n;
    logic batt_ok;
    logic reg_ok;
  } lt_pins_s;

endpackage

// ==== logic/lt_transceiver.sv ====
// control logic of the single-wire link transceiver with ahb-lite registers
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module lt_transceiver #(
  parameter logic [23:0] DOM_CYC    = lt_pkg::DOM_CYC,
  parameter logic [23:0] RST_CYC    = lt_pkg::RST_CYC,
  parameter logic [23:0] WD_CYC     = lt_pkg::WD_CYC,
  parameter bit          NO_TIMEOUT = 1'b0
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             irq,
  input  wire logic        txd_i,
  output logic             txd_o,
  output logic             txd_oe,
  input  wire logic        lin_i,
  output logic             lin_o,
  output logic             lin_oe,
  output logic             rxd,
  input  wire logic        wake_sw,
  input  wire logic        ignition_sense,
  input  wire logic        en,
  input  wire logic        watchdog_off,
  input  wire logic        watchdog_kick_n,
  input  wire logic        battery_ok,
  input  wire logic        regulator_sense_ok,
  output logic             reset_out_n_o,
  output logic             reset_out_n_oe,
  output logic             ext_regulator_ctrl,
  output logic             regulator_en
);

  function automatic logic rise(input logic was, input logic now);
    return !was && now;
  endfunction

  lt_pkg::lt_pins_s      pin_raw;
  lt_pkg::lt_pins_s      s1;
  lt_pkg::lt_pins_s      s;
  lt_pkg::lt_pins_s      prev;
  lt_pkg::lt_mode_e      mode;
  lt_pkg::lt_mode_e      next_mode;
  logic [23:0]           dom_cnt;
  logic [23:0]           next_dom_cnt;
  logic [10:0]           hi_cnt;
  logic [10:0]           next_hi_cnt;
  logic                  timed_out;
  logic                  next_timed_out;
  logic [23:0]           rst_cnt;
  logic [23:0]           next_rst_cnt;
  logic [23:0]           wd_cnt;
  logic [23:0]           next_wd_cnt;
  logic                  wake_local;
  logic                  next_wake_local;
  logic                  wake_bus;
  logic                  next_wake_bus;
  logic [31:0]           ctrl;
  logic [31:0]           next_ctrl;
  logic [lt_pkg::IRQ_W-1:0] irq_stat;
  logic [lt_pkg::IRQ_W-1:0] next_irq_stat;
  logic [lt_pkg::IRQ_W-1:0] irq_en;
  logic [lt_pkg::IRQ_W-1:0] next_irq_en;
  logic [lt_pkg::IRQ_W-1:0] ev;
  logic [lt_pkg::IRQ_W-1:0] clr;
  logic                  ap_wr;
  logic                  next_ap_wr;
  logic [7:0]            ap_addr;
  logic [7:0]            next_ap_addr;
  logic [31:0]           next_hrdata;
  logic                  rst_active;
  logic                  wd_expire;
  logic                  to_en;
  logic                  bus_wake;
  logic                  loc_wake;
  logic                  next_lin_oe;
  logic                  next_txd_oe;
  logic                  next_rxd;
  logic                  next_rst_oe;
  logic                  next_inh;
  logic                  next_reg_en;
  logic                  next_irq;

  assign pin_raw = '{txd: txd_i, lin: lin_i, wake_sw: wake_sw, ign: ignition_sense, en: en,
                     wd_off: watchdog_off, kick_n: watchdog_kick_n, batt_ok: battery_ok,
                     reg_ok: regulator_sense_ok};

  // two-stage synchroniser; prev only reads the second stage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1   <= '1;
      s    <= '1;
      prev <= '1;
    end else begin
      s1   <= pin_raw;
      s    <= s1;
      prev <= s;
    end
  end

  always_comb begin
    rst_active = (rst_cnt != 24'h000000);
    to_en      = !NO_TIMEOUT && ctrl[lt_pkg::CTRL_TO_EN];
    bus_wake   = rise(prev.lin, s.lin);
    loc_wake   = rise(s.wake_sw, prev.wake_sw) || rise(prev.ign, s.ign);
    next_mode       = mode;
    next_wake_local = wake_local;
    next_wake_bus   = wake_bus;
    case (mode)
      lt_pkg::FAILSAFE: begin
        // stay in fail-safe while the reset pulse runs, or it would bounce with
        if (s.en && !rst_active) begin
          next_mode = lt_pkg::NORMAL;
        end
      end
      lt_pkg::NORMAL: begin
        if (rst_active) begin
          next_mode = lt_pkg::FAILSAFE;
        end else if (rise(s.en, prev.en)) begin
          next_mode = s.txd ? lt_pkg::SILENT : lt_pkg::SLEEP;
        end
      end
      lt_pkg::SILENT, lt_pkg::SLEEP: begin
        if (s.en) begin
          next_mode = lt_pkg::NORMAL;
        end else if (bus_wake || loc_wake) begin
          next_mode       = lt_pkg::FAILSAFE;
          next_wake_local = loc_wake;
          next_wake_bus   = !loc_wake;
        end else if (mode == lt_pkg::SILENT && rst_active) begin
          next_mode = lt_pkg::FAILSAFE;
        end
      end
      default: next_mode = lt_pkg::FAILSAFE;
    endcase
    if (next_mode == lt_pkg::NORMAL) begin
      next_wake_local = 1'b0;
      next_wake_bus   = 1'b0;
    end

    // dominant time-out and its re-arm
    next_dom_cnt   = dom_cnt;
    next_hi_cnt    = hi_cnt;
    next_timed_out = timed_out;
    if (!s.txd) begin
      next_hi_cnt = 11'h000;
      if (dom_cnt != DOM_CYC) begin
        next_dom_cnt = dom_cnt + 24'h000001;
      end else if (to_en) begin
        next_timed_out = 1'b1;
      end
    end else begin
      next_dom_cnt = 24'h000000;
      if (timed_out) begin
        if (hi_cnt == lt_pkg::REARM_CYC) begin
          next_timed_out = 1'b0;
          next_hi_cnt    = 11'h000;
        end else begin
          next_hi_cnt = hi_cnt + 11'h001;
        end
      end
    end
    if (!to_en) begin
      next_timed_out = 1'b0;
    end

    // watchdog, serviced by a falling kick edge
    wd_expire   = 1'b0;
    next_wd_cnt = wd_cnt + 24'h000001;
    if (s.wd_off || rst_active || !(mode == lt_pkg::NORMAL || mode == lt_pkg::FAILSAFE)) begin
      next_wd_cnt = 24'h000000;
    end else if (rise(s.kick_n, prev.kick_n)) begin
      next_wd_cnt = 24'h000000;
    end else if (wd_cnt == WD_CYC - 24'h000001) begin
      wd_expire   = 1'b1;
      next_wd_cnt = 24'h000000;
    end

    // combined reset stretcher
    next_rst_cnt = rst_cnt;
    if (wd_expire || (!s.reg_ok && mode != lt_pkg::SLEEP)) begin
      next_rst_cnt = RST_CYC;
    end else if (rst_active) begin
      next_rst_cnt = rst_cnt - 24'h000001;
    end

    // pin outputs
    // gate on next_mode: no dominant pulse on the way into sleep, which would wake
    next_lin_oe = (next_mode == lt_pkg::NORMAL) && !s.txd && !timed_out && s.batt_ok;
    next_txd_oe = (mode == lt_pkg::FAILSAFE) && wake_local;
    case (mode)
      lt_pkg::NORMAL:   next_rxd = s.lin;
      lt_pkg::FAILSAFE: next_rxd = !wake_bus;
      lt_pkg::SILENT:   next_rxd = 1'b1;
      default:          next_rxd = 1'b0;
    endcase
    next_rst_oe = rst_active || mode == lt_pkg::SLEEP;
    next_reg_en = (mode != lt_pkg::SLEEP);
    next_inh    = (mode == lt_pkg::NORMAL || mode == lt_pkg::FAILSAFE) && s.reg_ok;

    // events, sticky status; a set beats a clear
    ev = '0;
    ev[lt_pkg::IRQ_TIMEOUT] = next_timed_out && !timed_out;
    ev[lt_pkg::IRQ_WAKE]    = next_mode == lt_pkg::FAILSAFE
                              && (mode == lt_pkg::SILENT || mode == lt_pkg::SLEEP);
    ev[lt_pkg::IRQ_WDOG]    = wd_expire;
    ev[lt_pkg::IRQ_REG_UV]  = rise(s.reg_ok, prev.reg_ok);
    ev[lt_pkg::IRQ_BATT_UV] = rise(s.batt_ok, prev.batt_ok);

    // ahb-lite slave, zero wait states
    next_ap_wr   = hsel && htrans[1] && hready && hwrite;
    next_ap_addr = haddr[7:0];
    next_hrdata  = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[7:0])
        lt_pkg::A_CTRL:     next_hrdata = ctrl;
        lt_pkg::A_STATUS:   next_hrdata = {26'h0, rst_active, wake_bus, wake_local,
                                           timed_out, mode};
        lt_pkg::A_IRQ_STAT: next_hrdata = {27'h0, irq_stat};
        lt_pkg::A_IRQ_EN:   next_hrdata = {27'h0, irq_en};
        default:            next_hrdata = 32'h0000_0000;
      endcase
    end
    next_ctrl   = ctrl;
    next_irq_en = irq_en;
    clr         = '0;
    if (ap_wr) begin
      case (ap_addr)
        lt_pkg::A_CTRL:    next_ctrl   = {31'h0, hwdata[lt_pkg::CTRL_TO_EN]};
        lt_pkg::A_IRQ_EN:  next_irq_en = hwdata[lt_pkg::IRQ_W-1:0];
        lt_pkg::A_IRQ_CLR: clr         = hwdata[lt_pkg::IRQ_W-1:0];
        default:           clr         = '0;
      endcase
    end
    next_irq_stat = (irq_stat & ~clr) | ev;
    next_irq      = |(next_irq_stat & next_irq_en);
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode               <= lt_pkg::FAILSAFE;
      dom_cnt            <= 24'h000000;
      hi_cnt             <= 11'h000;
      timed_out          <= 1'b0;
      wd_cnt             <= 24'h000000;
      rst_cnt            <= RST_CYC;
      wake_local         <= 1'b0;
      wake_bus           <= 1'b0;
      ctrl               <= lt_pkg::CTRL_RST;
      irq_stat           <= '0;
      irq_en             <= '0;
      ap_wr              <= 1'b0;
      ap_addr            <= 8'h00;
      hrdata             <= 32'h0000_0000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      irq                <= 1'b0;
      txd_o              <= 1'b0;
      txd_oe             <= 1'b0;
      lin_o              <= 1'b0;
      lin_oe             <= 1'b0;
      rxd                <= 1'b1;
      reset_out_n_o      <= 1'b0;
      reset_out_n_oe     <= 1'b1;
      ext_regulator_ctrl <= 1'b0;
      regulator_en       <= 1'b1;
    end else begin
      mode               <= next_mode;
      dom_cnt            <= next_dom_cnt;
      hi_cnt             <= next_hi_cnt;
      timed_out          <= next_timed_out;
      wd_cnt             <= next_wd_cnt;
      rst_cnt            <= next_rst_cnt;
      wake_local         <= next_wake_local;
      wake_bus           <= next_wake_bus;
      ctrl               <= next_ctrl;
      irq_stat           <= next_irq_stat;
      irq_en             <= next_irq_en;
      ap_wr              <= next_ap_wr;
      ap_addr            <= next_ap_addr;
      hrdata             <= next_hrdata;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      irq                <= next_irq;
      txd_o              <= 1'b0;
      txd_oe             <= next_txd_oe;
      lin_o              <= 1'b0;
      lin_oe             <= next_lin_oe;
      rxd                <= next_rxd;
      reset_out_n_o      <= 1'b0;
      reset_out_n_oe     <= next_rst_oe;
      ext_regulator_ctrl <= next_inh;
      regulator_en       <= next_reg_en;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_dom_drive;
    next_mode == lt_pkg::NORMAL && !s.txd && !timed_out && s.batt_ok |=> lin_oe;
  endproperty
  a_dom_drive: assert property (p_dom_drive) else $error("bus not driven dominant");

  property p_rec_release;
    s.txd |=> !lin_oe;
  endproperty
  a_rec_release: assert property (p_rec_release) else $error("bus driven while txd high");

  property p_timeout;
    to_en && !s.txd && dom_cnt == DOM_CYC |=> timed_out ##1 !lin_oe;
  endproperty
  a_timeout: assert property (p_timeout) else $error("dominant time-out missed");

  property p_rearm;
    $fell(timed_out) && to_en |-> $past(s.txd) && $past(hi_cnt) == lt_pkg::REARM_CYC;
  endproperty
  a_rearm: assert property (p_rearm) else $error("driver re-armed too early");

  property p_no_timeout;
    NO_TIMEOUT |-> !timed_out;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("time-out with option off");

  property p_txd_out;
    mode == lt_pkg::FAILSAFE && wake_local |=> txd_oe && !txd_o;
  endproperty
  a_txd_out: assert property (p_txd_out) else $error("txd not latched low");

  property p_batt_block;
    !s.batt_ok |=> !lin_oe;
  endproperty
  a_batt_block: assert property (p_batt_block) else $error("transmit in undervoltage");

  property p_wd_reset;
    wd_expire |-> ##2 reset_out_n_oe [*8];
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset too short");

  property p_wd_off;
    s.wd_off |=> wd_cnt == 24'h000000;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog runs while off");

  property p_normal;
    mode != lt_pkg::NORMAL && s.en && !rst_active |=> mode == lt_pkg::NORMAL;
  endproperty
  a_normal: assert property (p_normal) else $error("enable did not enter normal");

  property p_rx_follow;
    mode == lt_pkg::NORMAL |=> rxd == $past(s.lin);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rxd not following bus");

  property p_silent;
    mode == lt_pkg::NORMAL && !rst_active && prev.en && !s.en && s.txd
      |=> mode == lt_pkg::SILENT;
  endproperty
  a_silent: assert property (p_silent) else $error("silent mode not entered");

  property p_fail_reset;
    mode == lt_pkg::NORMAL && rst_active |=> mode == lt_pkg::FAILSAFE;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("reset did not force fail-safe");

  c_timeout: cover property (!timed_out ##1 timed_out);
  c_sleep: cover property (mode == lt_pkg::NORMAL ##1 mode == lt_pkg::SLEEP);
  c_wake: cover property (mode == lt_pkg::SLEEP ##1 mode == lt_pkg::FAILSAFE && wake_local);
  c_wdog: cover property (wd_expire);

endmodule // lt_transceiver

// ==== verif/lt_host_model.sv ====
// behavioural host microcontroller driving transmit, enable and watchdog kick
`timescale 1ns/100ps
module lt_host_model (
  input  wire logic clock,
  input  wire logic txd_oe,
  output wire logic txd_i,
  output logic      en,
  output logic      watchdog_kick_n
);
  logic host_low;

  // internal pull-up wins when neither side pulls low
  assign txd_i = ~(host_low | txd_oe);

  initial begin
    host_low = 1'b0;
    en = 1'b0;
    watchdog_kick_n = 1'b1;
  end

  task automatic set_txd(input logic lvl);
    @(posedge clock);
    host_low <= ~lvl;
  endtask

  task automatic set_en(input logic lvl);
    @(posedge clock);
    en <= lvl;
  endtask

  task automatic set_en_txd(input logic en_lvl, input logic txd_lvl);
    @(posedge clock);
    en       <= en_lvl;
    host_low <= ~txd_lvl;
  endtask

  task automatic kick();
    @(posedge clock);
    watchdog_kick_n <= 1'b0;
    repeat (4) @(posedge clock);
    watchdog_kick_n <= 1'b1;
  endtask
endmodule // lt_host_model

// ==== verif/tb_lt_transceiver.sv ====
// self-checking bench for the transceiver control with ahb-lite master
`timescale 1ns/100ps
module tb_lt_transceiver;
  localparam logic [23:0] DOM   = 24'h000028;
  localparam logic [23:0] RST   = 24'h00001E;
  localparam logic [23:0] WDC   = 24'h000064;
  localparam int          REARM = int'(lt_pkg::REARM_CYC) + 1;
  logic        clock, resetn, hsel, hwrite, hreadyout, hresp, irq, rxd;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        txd_o, txd_oe, lin_o, lin_oe, reset_out_n_o, reset_out_n_oe;
  logic        wake_sw, ignition_sense, watchdog_off, battery_ok, regulator_sense_ok;
  logic        ext_regulator_ctrl, regulator_en;
  wire         txd_i, en, watchdog_kick_n, lin_i, hready;
  int          failures, num_checks;

  assign hready = hreadyout;
  // bus pull-up: recessive unless the device pulls it
  assign lin_i = ~lin_oe;

  always #4 clock = ~clock;

  lt_transceiver #(.DOM_CYC(DOM), .RST_CYC(RST), .WD_CYC(WDC), .NO_TIMEOUT(1'b0))
    lt_transceiver_inst (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq), .txd_i(txd_i),
    .txd_o(txd_o), .txd_oe(txd_oe), .lin_i(lin_i), .lin_o(lin_o), .lin_oe(lin_oe),
    .rxd(rxd), .wake_sw(wake_sw), .ignition_sense(ignition_sense), .en(en),
    .watchdog_off(watchdog_off), .watchdog_kick_n(watchdog_kick_n),
    .battery_ok(battery_ok), .regulator_sense_ok(regulator_sense_ok),
    .reset_out_n_o(reset_out_n_o), .reset_out_n_oe(reset_out_n_oe),
    .ext_regulator_ctrl(ext_regulator_ctrl), .regulator_en(regulator_en));

  lt_host_model lt_host_model_inst (.clock(clock), .txd_oe(txd_oe), .txd_i(txd_i),
    .en(en), .watchdog_kick_n(watchdog_kick_n));

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(what, exp, v);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] dummy;
    ahb(1'b1, a, v, dummy);
  endtask

  task automatic chk_mode(input logic [1:0] m);
    ahb(1'b0, lt_pkg::A_STATUS, 32'h0, d);
    chk("mode", 32'(m), 32'(d[1:0]));
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    cyc(20000);
    failures++;
    conclude();
  end

  initial begin
    clock = 1'b0;
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wake_sw = 1'b1;
    ignition_sense = 1'b0;
    watchdog_off = 1'b1;
    battery_ok = 1'b1;
    regulator_sense_ok = 1'b1;
    failures = 0;
    num_checks = 0;
    cyc(8);
    resetn <= 1'b1;
    cyc(int'(RST) - 5);
    chk("power-on reset", 32'h1, 32'(reset_out_n_oe));
    cyc(10);
    chk("power-on reset", 32'h0, 32'(reset_out_n_oe));
    chk_mode(2'h0);
    chk("regulator_en", 32'h1, 32'(regulator_en));
    rd_chk("ctrl", lt_pkg::A_CTRL, lt_pkg::CTRL_RST);
    rd_chk("unmapped", 8'h40, 32'h0);
    wr(lt_pkg::A_IRQ_EN, 32'h0000_001F);
    rd_chk("irq_en", lt_pkg::A_IRQ_EN, 32'h0000_001F);
    lt_host_model_inst.set_en(1'b1);
    cyc(6);
    chk_mode(2'h1);
    lt_host_model_inst.set_txd(1'b0);
    cyc(7);
    chk("lin_oe", 32'h1, 32'(lin_oe));
    chk("rxd", 32'h0, 32'(rxd));
    lt_host_model_inst.set_txd(1'b1);
    cyc(7);
    chk("lin_oe", 32'h0, 32'(lin_oe));
    chk("rxd", 32'h1, 32'(rxd));
    lt_host_model_inst.set_txd(1'b0);
    cyc(int'(DOM) - 5);
    chk("lin_oe before time-out", 32'h1, 32'(lin_oe));
    cyc(13);
    chk("lin_oe after time-out", 32'h0, 32'(lin_oe));
    chk_mode(2'h1);
    chk("timed_out", 32'h1, 32'(d[2]));
    rd_chk("irq_stat", lt_pkg::A_IRQ_STAT, 32'h0000_0001);
    chk("irq", 32'h1, 32'(irq));
    wr(lt_pkg::A_IRQ_CLR, 32'h0000_001F);
    cyc(2);
    chk("irq", 32'h0, 32'(irq));
    lt_host_model_inst.set_txd(1'b1);
    cyc(REARM - 200);
    lt_host_model_inst.set_txd(1'b0);
    cyc(5);
    chk("lin_oe short release", 32'h0, 32'(lin_oe));
    lt_host_model_inst.set_txd(1'b1);
    cyc(REARM + 10);
    lt_host_model_inst.set_txd(1'b0);
    cyc(5);
    chk("lin_oe re-armed", 32'h1, 32'(lin_oe));
    battery_ok <= 1'b0;
    cyc(5);
    chk("lin_oe undervoltage", 32'h0, 32'(lin_oe));
    lt_host_model_inst.set_txd(1'b1);
    battery_ok <= 1'b1;
    rd_chk("irq_stat", lt_pkg::A_IRQ_STAT, 32'h0000_0010);
    lt_host_model_inst.set_en(1'b0);
    cyc(6);
    chk_mode(2'h2);
    ignition_sense <= 1'b1;
    cyc(6);
    chk_mode(2'h0);
    ignition_sense <= 1'b0;
    lt_host_model_inst.set_en(1'b1);
    cyc(6);
    chk_mode(2'h1);
    lt_host_model_inst.set_en_txd(1'b0, 1'b0);
    cyc(6);
    chk_mode(2'h3);
    chk("regulator_en", 32'h0, 32'(regulator_en));
    chk("ext_regulator_ctrl", 32'h0, 32'(ext_regulator_ctrl));
    lt_host_model_inst.set_txd(1'b1);
    wake_sw <= 1'b0;
    cyc(6);
    chk_mode(2'h0);
    chk("txd pin", 32'h0, 32'(txd_i));
    wake_sw <= 1'b1;
    cyc(int'(RST) + 10);
    lt_host_model_inst.set_en(1'b1);
    cyc(6);
    chk_mode(2'h1);
    regulator_sense_ok <= 1'b0;
    cyc(6);
    chk("reset undervoltage", 32'h1, 32'(reset_out_n_oe));
    chk_mode(2'h0);
    regulator_sense_ok <= 1'b1;
    cyc(int'(RST) + 10);
    chk("reset released", 32'h0, 32'(reset_out_n_oe));
    watchdog_off <= 1'b0;
    repeat (4) begin
      lt_host_model_inst.kick();
      cyc(40);
    end
    chk("reset serviced", 32'h0, 32'(reset_out_n_oe));
    cyc(int'(WDC) - 30);
    chk("reset watchdog", 32'h1, 32'(reset_out_n_oe));
    watchdog_off <= 1'b1;
    ahb(1'b0, lt_pkg::A_IRQ_STAT, 32'h0, d);
    chk("watchdog flag", 32'h1, 32'(d[2]));
    conclude();
  end
endmodule // tb_lt_transceiver
